// ### cmpc_pkg.sv
`default_nettype none
package cmpc_pkg;

  // register map (byte addresses on the plain register port)
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
  localparam logic [3:0] ADDR_PORT_READ = 4'hC;

  // control register field positions
  localparam int BIT_PIN_SELECT = 7;
  localparam int BIT_POWER_ON = 6;
  localparam int BIT_INVERT = 5;
  localparam int BIT_RESULT = 4;
  localparam int BIT_OUT_PATH = 3;
  localparam int BIT_EDGE_HI = 2;
  localparam int BIT_EDGE_LO = 1;
  localparam int BIT_HYST = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h81;
  localparam logic [7:0] CONTROL_WMASK = 8'hEF;

  // status/mask layout: bit 0 edge event
  localparam int IRQ_BIT_EDGE = 0;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  localparam int SYNC_STAGES = 2;

  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  typedef struct packed {
    logic pin_select;
    logic power_on;
    logic invert;
    logic out_path;
    logic [1:0] edge_sel;
    logic hyst;
  } cmpc_ctrl_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cmpc_bus_s;

endpackage
`default_nettype wire

// ### cmpc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module cmpc_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic [STAGES-1:0] chain;

  // first stage feeds only the next stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chain <= '0;
    end else begin
      chain <= {chain[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain[STAGES-1];
endmodule // cmpc_sync
`default_nettype wire

// ### cmpc_edge.sv
`timescale 1ns/100ps
`default_nettype none
module cmpc_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  input wire logic [1:0] edge_sel,
  output logic hit
);
  logic prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  always_comb begin
    case (edge_sel)
      cmpc_pkg::EDGE_RISE: hit = level & ~prev;
      cmpc_pkg::EDGE_FALL: hit = ~level & prev;
      default: hit = level ^ prev;
    endcase
  end
endmodule // cmpc_edge
`default_nettype wire

// ### cmpc_top.sv
// Function
// - result change sets flag; enable requests vector
// - edges taken from internal result, not pin
// - 00 rising, 01 falling, 1x both edges
// - flag set while asleep and powered on raises wake request
// - comparator keeps running in sleep/idle
// - shared pin reads: zero or port data
// - bit 7 selects comparator inputs over I/O
// - pull-highs dropped when inputs selected, enabled
// - bit 6 powers comparator on or off
// - bit 5 inverts result before storing
// - bit 4 read-only adjusted comparison result
// - bit 3 routes result to pin or internal
// - bit 0 enables hysteresis
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module cmpc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic analog_out,
  input wire logic sleep_mode,
  input wire logic [1:0] port_ctrl,
  input wire logic [1:0] port_data,
  output logic irq,
  output logic wake_req,
  output logic power_on,
  output logic hysteresis_on,
  output logic inputs_connected,
  output logic pullhigh_disable,
  output logic compare_output_pin,
  output logic compare_output_pin_oe
);

  ////////////////////////////////////////////////////////////////////////
  // register port

  cmpc_pkg::cmpc_bus_s bus;
  cmpc_pkg::cmpc_ctrl_s ctrl;
  logic [7:0] comparator_control;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic comparator_result;
  logic edge_hit;
  logic raw_sync;
  logic next_result;
  logic [1:0] port_view;
  logic [1:0] port_ctrl_s1;
  logic [1:0] port_ctrl_s2;
  logic [1:0] port_data_s1;
  logic [1:0] port_data_s2;
  logic sleep_s1;
  logic sleep_s2;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic hit_addr(input cmpc_pkg::cmpc_bus_s b,
                                    input logic [3:0] a);
    hit_addr = (b.addr == a);
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comparator_control <= cmpc_pkg::CONTROL_RESET;
    end else if (bus.wr && hit_addr(bus, cmpc_pkg::ADDR_CONTROL)) begin
      comparator_control <= bus.wdata & cmpc_pkg::CONTROL_WMASK;
    end
  end

  assign ctrl.pin_select = comparator_control[cmpc_pkg::BIT_PIN_SELECT];
  assign ctrl.power_on = comparator_control[cmpc_pkg::BIT_POWER_ON];
  assign ctrl.invert = comparator_control[cmpc_pkg::BIT_INVERT];
  assign ctrl.out_path = comparator_control[cmpc_pkg::BIT_OUT_PATH];
  assign ctrl.edge_sel = {comparator_control[cmpc_pkg::BIT_EDGE_HI],
                          comparator_control[cmpc_pkg::BIT_EDGE_LO]};
  assign ctrl.hyst = comparator_control[cmpc_pkg::BIT_HYST];

  ////////////////////////////////////////////////////////////////////////
  // pin-domain inputs

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_ctrl_s1 <= 2'h0;
      port_ctrl_s2 <= 2'h0;
      port_data_s1 <= 2'h0;
      port_data_s2 <= 2'h0;
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
    end else begin
      port_ctrl_s1 <= port_ctrl;
      port_ctrl_s2 <= port_ctrl_s1;
      port_data_s1 <= port_data;
      port_data_s2 <= port_data_s1;
      sleep_s1 <= sleep_mode;
      sleep_s2 <= sleep_s1;
    end
  end

  cmpc_sync #(.STAGES(cmpc_pkg::SYNC_STAGES)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(analog_out),
    .sync_out(raw_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // result bit and edge detection

  // powered-off comparator yields a constant low raw output
  assign next_result = (raw_sync & ctrl.power_on) ^ ctrl.invert;

  // runs regardless of sleep so wake-ups can occur
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comparator_result <= 1'b0;
    end else begin
      comparator_result <= next_result;
    end
  end

  cmpc_edge u_edge (
    .clk(clk),
    .rst(rst),
    .level(comparator_result),
    .edge_sel(ctrl.edge_sel),
    .hit(edge_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, mask, outputs

  logic clr_edge;
  assign clr_edge = bus.wr && hit_addr(bus, cmpc_pkg::ADDR_IRQ_STATUS)
                    && bus.wdata[cmpc_pkg::IRQ_BIT_EDGE];

  // a preset flag sees no new set event, so no fresh wake pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status <= cmpc_pkg::IRQ_RESET;
    end else if (edge_hit) begin
      irq_status[cmpc_pkg::IRQ_BIT_EDGE] <= 1'b1;
    end else if (clr_edge) begin
      irq_status[cmpc_pkg::IRQ_BIT_EDGE] <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask <= cmpc_pkg::IRQ_RESET;
    end else if (bus.wr && hit_addr(bus, cmpc_pkg::ADDR_IRQ_MASK)) begin
      irq_mask <= {7'h00, bus.wdata[cmpc_pkg::IRQ_BIT_EDGE]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask) | (edge_hit & irq_mask[0]);
    end
  end

  // wake only on a genuine new setting of the flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= edge_hit & sleep_s2 & ctrl.power_on
                  & ~irq_status[cmpc_pkg::IRQ_BIT_EDGE];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_on <= 1'b0;
      hysteresis_on <= 1'b0;
      inputs_connected <= 1'b0;
      pullhigh_disable <= 1'b0;
      compare_output_pin <= 1'b0;
      compare_output_pin_oe <= 1'b0;
    end else begin
      power_on <= ctrl.power_on;
      hysteresis_on <= ctrl.hyst;
      inputs_connected <= ctrl.pin_select;
      pullhigh_disable <= ctrl.pin_select & ctrl.power_on;
      compare_output_pin <= comparator_result;
      compare_output_pin_oe <= ~ctrl.out_path & ctrl.power_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  // same masking for each shared pin
  for (genvar i = 0; i < 2; i++) begin : g_port_view
    assign port_view[i] = port_ctrl_s2[i] ? 1'b0 : port_data_s2[i];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        cmpc_pkg::ADDR_CONTROL: begin
          reg_rdata <= {comparator_control[7:5], comparator_result,
                        comparator_control[3:0]};
        end
        cmpc_pkg::ADDR_IRQ_STATUS: reg_rdata <= irq_status;
        cmpc_pkg::ADDR_IRQ_MASK: reg_rdata <= irq_mask;
        cmpc_pkg::ADDR_PORT_READ: begin
          reg_rdata <= (ctrl.pin_select && ctrl.power_on) ?
                       {6'h00, port_view} : {6'h00, port_data_s2};
        end
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  a_flag_on_edge: assert property (
    @(posedge clk) disable iff (rst)
    edge_hit |=> irq_status[0])
    else $error("edge did not set flag");

  a_set_beats_clear: assert property (
    @(posedge clk) disable iff (rst)
    (edge_hit && clr_edge) |=> irq_status[0])
    else $error("clear beat a same-cycle edge");

  a_flag_sticky: assert property (
    @(posedge clk) disable iff (rst)
    (irq_status[0] && !clr_edge) |=> irq_status[0])
    else $error("flag dropped without clear");

  a_clear_works: assert property (
    @(posedge clk) disable iff (rst)
    (clr_edge && !edge_hit) |=> !irq_status[0])
    else $error("clear did not drop flag");

  a_no_stray_set: assert property (
    @(posedge clk) disable iff (rst)
    (!irq_status[0] && !edge_hit) |=> !irq_status[0])
    else $error("flag set without edge");

  a_edge_needs_change: assert property (
    @(posedge clk) disable iff (rst)
    edge_hit |-> $changed(comparator_result))
    else $error("edge without result change");

  a_rise_edge: assert property (
    @(posedge clk) disable iff (rst)
    (ctrl.edge_sel == cmpc_pkg::EDGE_RISE && $rose(comparator_result))
    |-> edge_hit)
    else $error("rising edge missed");

  a_fall_ignored: assert property (
    @(posedge clk) disable iff (rst)
    (ctrl.edge_sel == cmpc_pkg::EDGE_RISE && $fell(comparator_result))
    |-> !edge_hit)
    else $error("falling edge fired in rise mode");

  a_fall_edge: assert property (
    @(posedge clk) disable iff (rst)
    (ctrl.edge_sel == cmpc_pkg::EDGE_FALL && $fell(comparator_result))
    |-> edge_hit)
    else $error("falling edge missed");

  a_both_edges: assert property (
    @(posedge clk) disable iff (rst)
    (ctrl.edge_sel[1] && $changed(comparator_result)) |-> edge_hit)
    else $error("change missed in both-edge mode");

  a_irq_follows: assert property (
    @(posedge clk) disable iff (rst)
    (irq_status[0] && irq_mask[0]) |=> irq)
    else $error("unmasked flag gave no interrupt");

  a_irq_masked: assert property (
    @(posedge clk) disable iff (rst)
    !irq_mask[0] |=> !irq)
    else $error("masked flag gave interrupt");

  a_result_path: assert property (
    @(posedge clk) disable iff (rst)
    comparator_result == $past(next_result))
    else $error("result not polarity adjusted");

  // the chain still holds reset zeros for two edges after release
  a_sync_depth: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst, 2) |-> raw_sync == $past(analog_out, 2))
    else $error("sync chain depth wrong");

  a_result_readback: assert property (
    @(posedge clk) disable iff (rst)
    $past(bus.rd && bus.addr == cmpc_pkg::ADDR_CONTROL)
    |-> reg_rdata[cmpc_pkg::BIT_RESULT] == $past(comparator_result))
    else $error("result bit not read back");

  a_wake_cond: assert property (
    @(posedge clk) disable iff (rst)
    wake_req |-> $past(sleep_s2 && ctrl.power_on && edge_hit))
    else $error("wake without cause");

  a_wake_fires: assert property (
    @(posedge clk) disable iff (rst)
    (sleep_s2 && ctrl.power_on && edge_hit && !irq_status[0])
    |=> wake_req)
    else $error("wake missed while asleep");

  a_wake_flag_clear: assert property (
    @(posedge clk) disable iff (rst)
    wake_req |-> !$past(irq_status[0]))
    else $error("wake with flag already set");

  a_pin_drive: assert property (
    @(posedge clk) disable iff (rst)
    compare_output_pin_oe |-> !$past(ctrl.out_path))
    else $error("pin driven while internal");

  a_oe_unpowered: assert property (
    @(posedge clk) disable iff (rst)
    !$past(ctrl.power_on) |-> !compare_output_pin_oe)
    else $error("pin driven while powered off");

  a_pin_follows: assert property (
    @(posedge clk) disable iff (rst)
    compare_output_pin == $past(comparator_result))
    else $error("pin does not follow result");

  a_pullhigh_ctrl: assert property (
    @(posedge clk) disable iff (rst)
    pullhigh_disable == $past(ctrl.pin_select && ctrl.power_on))
    else $error("pull-high control wrong");

  a_port_masked: assert property (
    @(posedge clk) disable iff (rst)
    $past(bus.rd && bus.addr == cmpc_pkg::ADDR_PORT_READ
          && ctrl.pin_select && ctrl.power_on && port_ctrl_s2[1])
    |-> !reg_rdata[1])
    else $error("port read not masked");

endmodule // cmpc_top
`default_nettype wire

// ### cmpc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cmpc_top_tb;
  logic clk, rst, reg_wr, reg_rd, analog_out, sleep_mode;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [1:0] port_ctrl, port_data;
  logic irq, wake_req, power_on, hysteresis_on, inputs_connected;
  logic pullhigh_disable, compare_output_pin, compare_output_pin_oe;
  int n_mismatch = 0;
  int check_count = 0;
  int w;
  cmpc_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .analog_out(analog_out),
    .sleep_mode(sleep_mode), .port_ctrl(port_ctrl),
    .port_data(port_data), .irq(irq), .wake_req(wake_req),
    .power_on(power_on), .hysteresis_on(hysteresis_on),
    .inputs_connected(inputs_connected),
    .pullhigh_disable(pullhigh_disable),
    .compare_output_pin(compare_output_pin),
    .compare_output_pin_oe(compare_output_pin_oe));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // change the analog level, then count wake pulses while the path settles
  task automatic set_an(logic v);
    w = 0;
    @(posedge clk);
    analog_out <= v;
    repeat (10) begin
      @(posedge clk);
      #1 if (wake_req === 1'b1) w++;
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(4'h0);
    chk("ctrl reset", 8'h81, rv);
    chk("inputs conn", 8'h01, inputs_connected);
    chk("hyst", 8'h01, hysteresis_on);
    chk("oe off", 8'h00, compare_output_pin_oe);
    rd(4'h2);
    chk("unmapped", 8'h00, rv);
  endtask
  task automatic t_basic;
    wr(4'h8, 8'h01);
    wr(4'h0, 8'h40);
    @(posedge clk);
    #1 chk("power", 8'h01, power_on);
    chk("hyst off", 8'h00, hysteresis_on);
    chk("pullhigh", 8'h00, pullhigh_disable);
    chk("oe on", 8'h01, compare_output_pin_oe);
    set_an(1'b1);
    rd(4'h4);
    chk("flag set", 8'h01, rv);
    chk("irq", 8'h01, irq);
    chk("pin", 8'h01, compare_output_pin);
    rd(4'h0);
    chk("result bit", 8'h50, rv);
    wr(4'h0, 8'hFF);
    rd(4'h0);
    chk("ro bit4", 8'hEF, rv);
    wr(4'h4, 8'h01);
    @(posedge clk);
    #1 chk("irq clear", 8'h00, irq);
  endtask
  task automatic t_edges;
    for (int s = 0; s < 4; s++) begin
      wr(4'h0, 8'h40 | 8'(s << 1));
      set_an(1'b0);
      wr(4'h4, 8'h01);
      set_an(1'b1);
      rd(4'h4);
      chk("rise", 8'(s != 1), rv);
      wr(4'h4, 8'h01);
      set_an(1'b0);
      rd(4'h4);
      chk("fall", 8'(s != 0), rv);
    end
  endtask
  task automatic t_invert;
    wr(4'h0, 8'h44);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h64);
    repeat (6) @(posedge clk);
    rd(4'h4);
    chk("inv flag", 8'h01, rv);
    rd(4'h0);
    chk("inv result", 8'h74, rv);
    wr(4'h0, 8'h6C);
    @(posedge clk);
    #1 chk("pin internal", 8'h00, compare_output_pin_oe);
  endtask
  task automatic t_sleep;
    wr(4'h0, 8'h44);
    // let the edge from the polarity change land before clearing
    repeat (4) @(posedge clk);
    wr(4'h4, 8'h01);
    @(posedge clk);
    sleep_mode <= 1'b1;
    repeat (4) @(posedge clk);
    set_an(1'b1);
    chk("wake", 8'h01, 8'(w));
    set_an(1'b0);
    chk("no wake", 8'h00, 8'(w));
    @(posedge clk);
    sleep_mode <= 1'b0;
  endtask
  // clear write sampled on the very edge that the rising result sets the flag, one edge after the result rises
  task automatic t_race;
    wr(4'h4, 8'h01);
    @(posedge clk);
    analog_out <= 1'b1;
    repeat (2) @(posedge clk);
    wr(4'h4, 8'h01);
    rd(4'h4);
    chk("set wins", 8'h01, rv);
    wr(4'h8, 8'h00);
    @(posedge clk);
    #1 chk("irq masked", 8'h00, irq);
  endtask
  task automatic t_port;
    wr(4'h0, 8'hC0);
    port_ctrl <= 2'b10;
    port_data <= 2'b11;
    repeat (4) @(posedge clk);
    rd(4'hC);
    chk("port read", 8'h01, rv);
    chk("pullhigh on", 8'h01, pullhigh_disable);
    chk("inputs sel", 8'h01, inputs_connected);
    wr(4'h0, 8'h80);
    rd(4'hC);
    chk("port raw", 8'h03, rv);
    chk("pullhigh off", 8'h00, pullhigh_disable);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #30000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    analog_out = 1'b0;
    sleep_mode = 1'b0;
    port_ctrl = 2'b00;
    port_data = 2'b00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_basic();
    t_edges();
    t_invert();
    t_sleep();
    t_race();
    t_port();
    give_verdict();
  end
endmodule // cmpc_top_tb
`default_nettype wire
